// File: design/xbus_params.svh
/*
  Constants of the external memory bus pin logic: bus phases, power-down pin
  filter counts, strap settle count and port fill values.
  Assumes one 125 MHz core clock, which is also the oscillator period.
*/
`ifndef XBUS_PARAMS_SVH
`define XBUS_PARAMS_SVH
// Phase of a three-period bus slot
`define XBUS_PH_ADDR 2'h0
`define XBUS_PH_STROBE 2'h1
`define XBUS_PH_LAST 2'h2
// One machine cycle and the power-down threshold, in core clocks
`define XBUS_MC_CLKS 8'h06
`define XBUS_PD_CLKS 8'h0C
// Edges before the synchronised strap is valid
`define XBUS_STRAP_SETTLE 2'h2
// Port fill values
`define XBUS_ONES 8'hFF
`define XBUS_ZEROS 8'h00
`endif

// File: design/xbus_pkg.sv
/*
  Types of the external memory bus pin logic: operations, slot kinds,
  request word and the registered pin image.
  Assumes nothing beyond SystemVerilog packed types.
*/
package xbus_pkg;
  // Operation asked by the core
  typedef enum logic [1:0] {XBUS_OP_FETCH, XBUS_OP_READ, XBUS_OP_WRITE} xbus_op_t;
  // Kind of the current three-period slot
  typedef enum logic [2:0] {SLOT_IDLE, SLOT_INT, SLOT_FETCH, SLOT_DADDR, SLOT_DXFER} xbus_slot_t;
  // One core request
  typedef struct packed {
    xbus_op_t op;
    logic wide;
    logic internal_src;
    logic [15:0] addr;
    logic [7:0] wdata;
  } xbus_req_t;
  // Image of every driven pin
  typedef struct packed {
    logic [7:0] high_out;
    logic [7:0] high_oe;
    logic [7:0] low_out;
    logic [7:0] low_oe;
    logic ale;
    logic strobe_n;
  } xbus_pins_t;
endpackage : xbus_pkg

// File: design/xbus_pd_filter.sv
/*
  Power-down pin filter: times how long the pin stays low and turns that
  into a reset pulse or a power-down level.
  Assumes the pin is asynchronous and the core clock keeps running.
*/
`timescale 1ns/10ps
`include "xbus_params.svh"
module xbus_pd_filter (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // Pin, active low
  input wire logic pd_pin_n_in,
  // Results
  output logic hw_reset_out,
  output logic powerdown_out
);
  logic s1_r; // First synchroniser stage
  logic s2_r; // Second stage, the only one read
  logic [7:0] low_cnt_r; // Clocks spent low, saturating

  // Two-stage synchroniser, idles high
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
    end else begin
      s1_r <= pd_pin_n_in;
      s2_r <= s1_r;
    end
  end

  // Low-time counter, cleared when the pin returns high
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      low_cnt_r <= 8'h00;
    end else if (s2_r) begin
      low_cnt_r <= 8'h00;
    end else if (low_cnt_r != `XBUS_PD_CLKS) begin
      low_cnt_r <= low_cnt_r + 8'h01;
    end
  end

  // reset on release
  // A release after a long low also wakes with a reset
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      hw_reset_out <= 1'b0;
    end else begin
      hw_reset_out <= s2_r && (low_cnt_r >= `XBUS_MC_CLKS);
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      powerdown_out <= 1'b0;
    end else begin
      powerdown_out <= !s2_r && (low_cnt_r == `XBUS_PD_CLKS);
    end
  end

  chk_pd_reset_pulse: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (s2_r && low_cnt_r >= `XBUS_MC_CLKS) |=> hw_reset_out ##1 !hw_reset_out)
    else $error("Power-down pin release gave no single reset pulse");
  chk_pd_enter: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (!s2_r && low_cnt_r == `XBUS_PD_CLKS) |=> powerdown_out)
    else $error("Long power-down pin low did not enter power-down");
endmodule : xbus_pd_filter

// File: design/xbus_pins.sv
/*
  External memory bus pin logic: slot sequencer, address latch and program
  strobes, high and low port drive, strap latch, flash programming enable.
  Assumes the core offers one request at a time and holds it until taken,
  and that the board resolves each port wire from its output enable.
*/
`timescale 1ns/10ps
`include "xbus_params.svh"
module xbus_pins
  import xbus_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // Board pins in
  input wire logic hw_powerdown_pin_n_in,
  input wire logic external_fetch_select_in,
  input wire logic flash_program_pin_in,
  input wire logic [7:0] low_port_pins_in,
  // Core side
  input wire logic flash_program_bit_in,
  input wire logic [7:0] high_port_latch_in,
  input wire logic [7:0] low_port_latch_in,
  input wire logic req_valid_in,
  input wire xbus_req_t req_in,
  // Board pins out
  output logic [7:0] high_port_out,
  output logic [7:0] high_port_oe_out,
  output logic [7:0] low_port_out,
  output logic [7:0] low_port_oe_out,
  output logic ale_out,
  output logic prog_store_strobe_n_out,
  // Core answers and status
  output logic req_taken_out,
  output logic rsp_valid_out,
  output logic [7:0] rsp_data_out,
  output logic fetch_external_out,
  output logic flash_prog_enable_out,
  output logic powerdown_out,
  output logic hw_reset_out
);
  logic [1:0] phase_r; // Position in the current slot
  logic [1:0] phase_nxt; // Position after this edge
  xbus_slot_t slot_r; // Current slot kind
  xbus_slot_t slot_nxt; // Kind of the slot that follows
  xbus_slot_t slot_up; // Kind seen after this edge
  xbus_req_t req_r; // Request owning the current slot
  xbus_req_t req_nxt; // Request for the next slot
  xbus_req_t req_up; // Request seen after this edge
  logic take_nxt; // A request is taken at this edge
  xbus_pins_t pins_r; // Registered pin image
  logic cap_pend_r; // Read data waits in the synchroniser
  logic rsp_valid_r; // Answer pulse
  logic [7:0] rsp_data_r; // Answer byte
  logic taken_r; // Take pulse
  logic strap_s1_r; // Strap synchroniser, first stage
  logic strap_s2_r; // Strap synchroniser, second stage
  logic [1:0] strap_cnt_r; // Settle counter after reset
  logic strap_ready_r; // Strap has been caught
  logic fetch_ext_r; // Fetches not marked internal go outside
  logic fp_s1_r; // Flash pin, first stage
  logic fp_s2_r; // Flash pin, second stage
  logic flash_en_r; // Flash programming mode
  logic [7:0] lad_s1_r; // Low port read, first stage
  logic [7:0] lad_s2_r; // Low port read, second stage
  logic pd_w; // Power-down level from the filter
  logic hwrst_w; // Reset pulse from the filter
  logic powerdown_r; // Registered power-down
  logic hwrst_r; // Registered reset pulse

  // Power-down pin timing lives in its own module
  xbus_pd_filter u_pd_filter (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .pd_pin_n_in(hw_powerdown_pin_n_in),
    .hw_reset_out(hwrst_w),
    .powerdown_out(pd_w)
  );

  // Pin image for a slot kind at a phase
  function automatic xbus_pins_t drive_pins(input xbus_slot_t slot, input logic [1:0] ph,
                                            input xbus_req_t rq, input logic [7:0] hi_latch,
                                            input logic [7:0] lo_latch, input logic flash_en);
    xbus_pins_t p;
    p = '0;
    // port mode: latch shown, zeros driven
    p.high_out = hi_latch;
    p.high_oe = ~hi_latch;
    p.low_out = `XBUS_ZEROS;
    p.low_oe = ~lo_latch;
    p.ale = (ph == `XBUS_PH_ADDR) && (slot != SLOT_DXFER);
    p.strobe_n = 1'b1;
    case (slot)
      SLOT_FETCH, SLOT_DADDR, SLOT_DXFER: begin
        if (slot == SLOT_FETCH || rq.wide) begin
          p.high_out = rq.addr[15:8];
          p.high_oe = `XBUS_ONES;
        end
        if (slot != SLOT_DXFER && ph == `XBUS_PH_ADDR) begin
          p.low_out = rq.addr[7:0];
          p.low_oe = `XBUS_ONES;
        end else if (slot == SLOT_DXFER && rq.op == XBUS_OP_WRITE) begin
          p.low_out = rq.wdata;
          p.low_oe = `XBUS_ONES;
        end else begin
          // Turned over so the memory can answer
          p.low_oe = `XBUS_ZEROS;
        end
        if (ph != `XBUS_PH_ADDR && slot == SLOT_FETCH) begin
          p.strobe_n = 1'b0;
        end
        if (ph != `XBUS_PH_ADDR && slot == SLOT_DXFER && rq.op == XBUS_OP_READ && flash_en) begin
          p.strobe_n = 1'b0;
        end
      end
      default: begin
        // Idle and internal slots keep port mode
      end
    endcase
    return p;
  endfunction : drive_pins

  // Phase advance, three periods per slot
  always_comb begin
    phase_nxt = (phase_r == `XBUS_PH_LAST) ? `XBUS_PH_ADDR : phase_r + 2'h1;
  end

  // Choice of the next slot
  always_comb begin
    slot_nxt = SLOT_IDLE;
    req_nxt = req_r;
    take_nxt = 1'b0;
    if (slot_r == SLOT_DADDR) begin
      // Data moves always use two slots
      slot_nxt = SLOT_DXFER;
    end else if (req_valid_in && strap_ready_r && !pd_w) begin
      take_nxt = (phase_r == `XBUS_PH_LAST);
      req_nxt = req_in;
      if (req_in.op != XBUS_OP_FETCH) begin
        slot_nxt = SLOT_DADDR;
      end else if (req_in.internal_src || !fetch_ext_r) begin
        slot_nxt = SLOT_INT;
      end else begin
        slot_nxt = SLOT_FETCH;
      end
    end
    slot_up = (phase_r == `XBUS_PH_LAST) ? slot_nxt : slot_r;
    req_up = (phase_r == `XBUS_PH_LAST) ? req_nxt : req_r;
  end

  // Slot sequencer; a filter reset restarts it
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      phase_r <= `XBUS_PH_LAST;
      slot_r <= SLOT_IDLE;
      req_r <= '0;
    end else if (hwrst_w) begin
      phase_r <= `XBUS_PH_LAST;
      slot_r <= SLOT_IDLE;
    end else begin
      phase_r <= phase_nxt;
      slot_r <= slot_up;
      req_r <= req_up;
    end
  end

  // Registered pins, phase-aligned with the sequencer
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pins_r <= '{high_out: 8'h00, high_oe: 8'h00, low_out: 8'h00, low_oe: 8'h00, ale: 1'b0, strobe_n: 1'b1};
    end else if (pd_w || hwrst_w) begin
      pins_r <= '{high_out: 8'h00, high_oe: 8'h00, low_out: 8'h00, low_oe: 8'h00, ale: 1'b0, strobe_n: 1'b1};
    end else begin
      pins_r <= drive_pins(slot_up, phase_nxt, req_up, high_port_latch_in, low_port_latch_in, flash_en_r);
    end
  end

  // Low port read path; a wide bus through two stages is safe here
  // only because the memory holds its byte for a short time after the strobe rises
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      lad_s1_r <= 8'h00;
      lad_s2_r <= 8'h00;
    end else begin
      lad_s1_r <= low_port_pins_in;
      lad_s2_r <= lad_s1_r;
    end
  end

  // Read capture two edges after the strobe slot ends
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cap_pend_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_data_r <= 8'h00;
    end else begin
      rsp_valid_r <= 1'b0;
      if (hwrst_w) begin
        cap_pend_r <= 1'b0;
      end else if (phase_r == `XBUS_PH_LAST &&
                   (slot_r == SLOT_FETCH || (slot_r == SLOT_DXFER && req_r.op == XBUS_OP_READ))) begin
        cap_pend_r <= 1'b1;
      end else if (phase_r == `XBUS_PH_STROBE && cap_pend_r) begin
        cap_pend_r <= 1'b0;
        rsp_valid_r <= 1'b1;
        rsp_data_r <= lad_s2_r;
      end
    end
  end

  // Take pulse to the core
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      taken_r <= 1'b0;
    end else begin
      taken_r <= take_nxt && !hwrst_w;
    end
  end

  // Strap synchroniser
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      strap_s1_r <= 1'b0;
      strap_s2_r <= 1'b0;
    end else begin
      strap_s1_r <= external_fetch_select_in;
      strap_s2_r <= strap_s1_r;
    end
  end

  // strap caught after reset
  // Requests wait until then, so no fetch uses a stale strap
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      strap_cnt_r <= 2'h0;
      strap_ready_r <= 1'b0;
      fetch_ext_r <= 1'b1;
    end else if (hwrst_w) begin
      strap_cnt_r <= 2'h0;
      strap_ready_r <= 1'b0;
    end else if (strap_cnt_r != `XBUS_STRAP_SETTLE) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
    end else if (!strap_ready_r) begin
      strap_ready_r <= 1'b1;
      fetch_ext_r <= !strap_s2_r;
    end
  end

  // Flash pin synchroniser
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      fp_s1_r <= 1'b0;
      fp_s2_r <= 1'b0;
    end else begin
      fp_s1_r <= flash_program_pin_in;
      fp_s2_r <= fp_s1_r;
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      flash_en_r <= 1'b0;
    end else begin
      flash_en_r <= fp_s2_r && flash_program_bit_in;
    end
  end

  // Status copies
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      powerdown_r <= 1'b0;
      hwrst_r <= 1'b0;
    end else begin
      powerdown_r <= pd_w;
      hwrst_r <= hwrst_w;
    end
  end

  // Ports straight from flip-flops
  assign high_port_out = pins_r.high_out;
  assign high_port_oe_out = pins_r.high_oe;
  assign low_port_out = pins_r.low_out;
  assign low_port_oe_out = pins_r.low_oe;
  assign ale_out = pins_r.ale;
  assign prog_store_strobe_n_out = pins_r.strobe_n;
  assign req_taken_out = taken_r;
  assign rsp_valid_out = rsp_valid_r;
  assign rsp_data_out = rsp_data_r;
  assign fetch_external_out = fetch_ext_r;
  assign flash_prog_enable_out = flash_en_r;
  assign powerdown_out = powerdown_r;
  assign hw_reset_out = hwrst_r;

  chk_high_addr_drive: assert property (@(posedge core_clk_in) disable iff (sys_rst_in || pd_w || powerdown_r)
    (slot_r == SLOT_FETCH || (slot_r inside {SLOT_DADDR, SLOT_DXFER} && req_r.wide))
    |-> (pins_r.high_out == req_r.addr[15:8]) && (pins_r.high_oe == 8'hFF))
    else $error("High port not driving the address byte");
  chk_high_latch_show: assert property (@(posedge core_clk_in) disable iff (sys_rst_in || pd_w || powerdown_r)
    (slot_r inside {SLOT_DADDR, SLOT_DXFER} && !req_r.wide && $stable(high_port_latch_in))
    |-> pins_r.high_oe == ~high_port_latch_in && pins_r.high_out == high_port_latch_in)
    else $error("High port not showing its latch on narrow access");
  chk_fetch_strobe: assert property (@(posedge core_clk_in) disable iff (sys_rst_in || pd_w || powerdown_r)
    (phase_r == `XBUS_PH_ADDR && slot_r == SLOT_FETCH)
    |-> pins_r.strobe_n ##1 !pins_r.strobe_n ##1 !pins_r.strobe_n)
    else $error("Program strobe shape wrong on fetch");
  chk_data_no_strobe: assert property (@(posedge core_clk_in) disable iff (sys_rst_in || pd_w || powerdown_r)
    (slot_r inside {SLOT_DADDR, SLOT_DXFER} && !flash_en_r && !$past(flash_en_r)) |-> pins_r.strobe_n)
    else $error("Program strobe active on data move");
  chk_int_no_strobe: assert property (@(posedge core_clk_in) disable iff (sys_rst_in || pd_w || powerdown_r)
    (slot_r == SLOT_INT) |-> pins_r.strobe_n && (pins_r.low_oe == ~$past(low_port_latch_in)))
    else $error("Bus activity during internal execution");
  chk_flash_read: assert property (@(posedge core_clk_in) disable iff (sys_rst_in || pd_w || powerdown_r)
    (phase_r == `XBUS_PH_ADDR && slot_r == SLOT_DXFER && req_r.op == XBUS_OP_READ && flash_en_r)
    |=> !pins_r.strobe_n)
    else $error("Flash read strobe missing in programming mode");
  chk_ale_cadence: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in || pd_w || powerdown_r || hwrst_w || hwrst_r)
    (phase_r == `XBUS_PH_ADDR) |-> (pins_r.ale == (slot_r != SLOT_DXFER)) ##1 !pins_r.ale ##1 !pins_r.ale)
    else $error("Address latch strobe out of cadence");
  chk_strap_latch: assert property (@(posedge core_clk_in) disable iff (sys_rst_in || hwrst_w)
    (strap_cnt_r == `XBUS_STRAP_SETTLE && !strap_ready_r) |=> strap_ready_r && (fetch_ext_r == !$past(strap_s2_r)))
    else $error("Fetch select not latched after reset");
  chk_flash_gate: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    !fp_s2_r |=> !flash_en_r)
    else $error("Flash programming enabled with pin low");
  chk_low_write_data: assert property (@(posedge core_clk_in) disable iff (sys_rst_in || pd_w || powerdown_r)
    (slot_r == SLOT_DXFER && req_r.op == XBUS_OP_WRITE)
    |-> pins_r.low_oe == 8'hFF && pins_r.low_out == req_r.wdata)
    else $error("Low port not driving write data");
  chk_pd_float: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    $rose(pd_w) |=> (pins_r.high_oe == 8'h00) && (pins_r.low_oe == 8'h00) && powerdown_r)
    else $error("Pins not floating in power-down");
  chk_addr_hold: assert property (@(posedge core_clk_in) disable iff (sys_rst_in || pd_w || powerdown_r)
    (phase_r == `XBUS_PH_ADDR && slot_r inside {SLOT_FETCH, SLOT_DADDR})
    |-> (pins_r.ale && pins_r.low_oe == 8'hFF && pins_r.low_out == req_r.addr[7:0]) ##1 (pins_r.low_oe == 8'h00))
    else $error("Low address not held through the latch strobe");
endmodule : xbus_pins

// File: test/xbus_mem_model.sv
/*
  External memory model for the bus pin logic: takes the address while the
  latch strobe is high and answers on the low port while the strobe is low.
  Assumes the testbench resolves the low port wire from every enable.
*/
`timescale 1ns/10ps
module xbus_mem_model (
  // Clock
  input wire logic core_clk_in,
  // Strobes and address from the device
  input wire logic ale_in,
  input wire logic strobe_n_in,
  input wire logic [7:0] high_in,
  input wire logic [7:0] low_in,
  // Data back onto the low port
  output logic [7:0] data_out,
  output logic data_oe_out
);
  logic [15:0] addr_r; // Captured address
  logic [1:0] hold_r = 2'h0; // Short output hold after the strobe rises

  // address taken at every edge while the latch strobe is high
  always_ff @(posedge core_clk_in) begin
    if (ale_in) begin
      addr_r <= {high_in, low_in};
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!strobe_n_in) begin
      hold_r <= 2'h2;
    end else if (hold_r != 2'h0) begin
      hold_r <= hold_r - 2'h1;
    end
  end

  // Drive only in the window; a real part lets go soon after
  assign data_oe_out = !strobe_n_in || (hold_r != 2'h0);
  // Contents: a fixed mix of both address bytes
  assign data_out = addr_r[7:0] ^ addr_r[15:8] ^ 8'h5A;
endmodule : xbus_mem_model

// File: test/tb_top.sv
/*
  Self-checking testbench for the external memory bus pin logic.
  Assumes the package types, a 125 MHz core clock and the memory model.
*/
`timescale 1ns/10ps
module tb_top
  import xbus_pkg::*;
;
  // Clock, reset, board inputs and the flash program bit
  logic core_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic pd_n = 1'b1;
  logic strap = 1'b0;
  logic fpin = 1'b0;
  logic fbit = 1'b0;
  // Core side stimulus
  logic [7:0] hi_latch = 8'h00;
  logic [7:0] lo_latch = 8'hFF;
  logic req_valid = 1'b0;
  xbus_req_t req = '0;
  // Design outputs
  logic [7:0] high_port_out, high_port_oe_out, low_port_out, low_port_oe_out, rsp_data_out;
  logic ale_out, prog_store_strobe_n_out, req_taken_out, rsp_valid_out;
  logic fetch_external_out, flash_prog_enable_out, powerdown_out, hw_reset_out;
  // Low port wire and memory drive
  logic [7:0] low_wire, mem_data;
  logic mem_oe;
  logic [7:0] float_r = 8'h00; // Undriven wire never holds its last level
  int err_total = 0;
  int samples_checked = 0;

  // 8 ns clock
  always #4 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) float_r <= ~float_r;

  // Priority-resolved wire: device first, then memory, else floating
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      low_wire[i] = low_port_oe_out[i] ? low_port_out[i] : (mem_oe ? mem_data[i] : float_r[i]);
    end
  end

  xbus_pins uut (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .hw_powerdown_pin_n_in(pd_n),
    .external_fetch_select_in(strap), .flash_program_pin_in(fpin), .low_port_pins_in(low_wire),
    .flash_program_bit_in(fbit), .high_port_latch_in(hi_latch), .low_port_latch_in(lo_latch),
    .req_valid_in(req_valid), .req_in(req), .high_port_out(high_port_out),
    .high_port_oe_out(high_port_oe_out), .low_port_out(low_port_out), .low_port_oe_out(low_port_oe_out),
    .ale_out(ale_out), .prog_store_strobe_n_out(prog_store_strobe_n_out), .req_taken_out(req_taken_out),
    .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out), .fetch_external_out(fetch_external_out),
    .flash_prog_enable_out(flash_prog_enable_out), .powerdown_out(powerdown_out),
    .hw_reset_out(hw_reset_out));

  xbus_mem_model mem (.core_clk_in(core_clk_in), .ale_in(ale_out), .strobe_n_in(prog_store_strobe_n_out),
    .high_in(high_port_out), .low_in(low_wire), .data_out(mem_data), .data_oe_out(mem_oe));

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Land just after a rising edge, outputs settled
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : tick

  // Reset with a chosen strap level, then let the strap be caught
  task automatic do_reset(input logic s);
    @(negedge core_clk_in);
    strap = s;
    sys_rst_in = 1'b1;
    repeat (3) @(negedge core_clk_in);
    sys_rst_in = 1'b0;
    tick(8);
  endtask : do_reset

  // Offer a request and hold it until taken; returns in the take cycle
  task automatic issue(input xbus_op_t op, input logic wide, input logic intl, input logic [15:0] a);
    int n;
    @(negedge core_clk_in);
    req = '{op: op, wide: wide, internal_src: intl, addr: a, wdata: a[15:8] ^ 8'h33};
    req_valid = 1'b1;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (req_taken_out !== 1'b1 && n < 40);
    chk(req_taken_out, 1'b1); // take seen
    @(negedge core_clk_in);
    req_valid = 1'b0;
  endtask : issue

  // Count strobe lows and latch pulses over n cycles
  task automatic watch(input int n, output int lows, output int ales);
    lows = 0;
    ales = 0;
    repeat (n) begin
      tick(1);
      lows += (prog_store_strobe_n_out === 1'b0);
      ales += (ale_out === 1'b1);
    end
  endtask : watch

  // Bounded wait for a response, then judge its data
  task automatic wait_rsp(input logic [7:0] exp);
    int n;
    n = 0;
    while (rsp_valid_out !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    chk({rsp_valid_out, rsp_data_out}, {1'b1, exp}); // answered byte
  endtask : wait_rsp

  // Bounded wait for the pin reset pulse
  task automatic wait_hwrst;
    int n;
    n = 0;
    while (hw_reset_out !== 1'b1 && n < 30) begin
      tick(1);
      n++;
    end
    chk(hw_reset_out, 1'b1); // pin reset fired
  endtask : wait_hwrst

  // Idle bus: strap result, open-drain port, latch pulse rate
  task automatic t_idle;
    int lows, ales;
    chk(fetch_external_out, 1'b1); // strap low caught
    chk({low_port_out, low_port_oe_out}, 16'h0000); // ones written float
    watch(30, lows, ales);
    chk(ales, 10); // one pulse per three periods
    chk(lows, 0); // no fetch, no strobe
    @(negedge core_clk_in) lo_latch = 8'h0F;
    tick(1);
    chk({low_port_out, low_port_oe_out}, 16'h00F0); // zeros driven, ones float
    @(negedge core_clk_in) lo_latch = 8'hFF;
  endtask : t_idle

  // External wide fetch with address phase and answer
  task automatic t_fetch;
    issue(XBUS_OP_FETCH, 1'b1, 1'b0, 16'h12C5);
    chk({high_port_out, high_port_oe_out}, 16'h12FF); // high byte driven strongly
    chk({ale_out, low_port_out, low_port_oe_out}, {1'b1, 16'hC5FF}); // low byte under latch strobe
    tick(1);
    chk({ale_out, prog_store_strobe_n_out, low_port_oe_out}, 10'h000); // port released, strobe low
    wait_rsp(8'h12 ^ 8'hC5 ^ 8'h5A); // answer
  endtask : t_fetch

  // Narrow read: high port shows its latch, no strobe, no second pulse
  task automatic t_narrow;
    int lows, ales;
    @(negedge core_clk_in) hi_latch = 8'h3C;
    issue(XBUS_OP_READ, 1'b0, 1'b0, 16'hAB77);
    chk({high_port_out, high_port_oe_out}, 16'h3CC3); // latch value, zeros driven
    watch(5, lows, ales);
    chk(lows, 0); // data move keeps strobe idle
    chk(ales, 0); // transfer slot skips pulse
    @(negedge core_clk_in) hi_latch = 8'h00;
    tick(6);
  endtask : t_narrow

  // Wide write: data phase on the low port
  task automatic t_write;
    issue(XBUS_OP_WRITE, 1'b1, 1'b0, 16'h4410);
    chk({high_port_out, high_port_oe_out}, 16'h44FF); // wide address
    tick(3);
    chk({ale_out, low_port_out, low_port_oe_out}, {1'b0, 8'h44 ^ 8'h33, 8'hFF}); // data driven
    tick(6);
  endtask : t_write

  // Internal fetch keeps the strobe idle
  task automatic t_internal;
    int lows, ales;
    issue(XBUS_OP_FETCH, 1'b1, 1'b1, 16'h0100);
    watch(5, lows, ales);
    chk(lows, 0); // internal source
  endtask : t_internal

  // Programming enable needs pin and bit; flash read strobe
  task automatic t_flash;
    @(negedge core_clk_in) fpin = 1'b1;
    tick(6);
    chk(flash_prog_enable_out, 1'b0); // bit clear
    @(negedge core_clk_in) fbit = 1'b1;
    tick(6);
    chk(flash_prog_enable_out, 1'b1); // pin and bit set
    issue(XBUS_OP_READ, 1'b1, 1'b0, 16'h2D81);
    tick(2);
    chk(prog_store_strobe_n_out, 1'b1); // idle in address slot
    tick(2);
    chk(prog_store_strobe_n_out, 1'b0); // read strobe in transfer slot
    wait_rsp(8'h2D ^ 8'h81 ^ 8'h5A); // flash byte
    @(negedge core_clk_in) fpin = 1'b0;
    tick(6);
    chk(flash_prog_enable_out, 1'b0); // low pin disables
    @(negedge core_clk_in) fbit = 1'b0;
  endtask : t_flash

  // Short low gives reset only; long low floats the pins
  task automatic t_powerdown;
    @(negedge core_clk_in) pd_n = 1'b0;
    repeat (8) @(negedge core_clk_in);
    pd_n = 1'b1;
    wait_hwrst();
    chk(powerdown_out, 1'b0); // no power-down on short low
    tick(10);
    @(negedge core_clk_in) pd_n = 1'b0;
    repeat (20) @(negedge core_clk_in);
    chk({powerdown_out, ale_out, prog_store_strobe_n_out, low_port_oe_out, high_port_oe_out},
        {3'b101, 16'h0000}); // pins floating
    pd_n = 1'b1;
    wait_hwrst();
    tick(10);
  endtask : t_powerdown

  // Strap high: fetches stay internal
  task automatic t_strap;
    int lows, ales;
    do_reset(1'b1);
    chk(fetch_external_out, 1'b0); // strap high caught
    issue(XBUS_OP_FETCH, 1'b1, 1'b0, 16'h0055);
    watch(5, lows, ales);
    chk(lows, 0); // no external fetch
    do_reset(1'b0);
  endtask : t_strap

  // Verdict and end of run
  task automatic stop_test;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  // Main sequence
  initial begin
    do_reset(1'b0);
    t_idle();
    t_fetch();
    t_narrow();
    t_write();
    t_internal();
    t_flash();
    t_powerdown();
    t_strap();
    stop_test();
  end

  // Watchdog, well beyond the few hundred cycles the tests need
  initial begin
    repeat (4000) @(posedge core_clk_in);
    err_total++;
    stop_test();
  end
endmodule : tb_top
